//--- sbrw_pkg.sv
// Summary of operation
// R1: With no remote write requested, the machine stays in its first idle state.
// R2: Request with lock-out or local grant waits in second idle state until both clear.
// R3: In idle states with bus hold high, local bus requests are granted.
// R4: Acknowledge goes low as soon as a remote write request appears.
// R5: With no local request and lock-out clear, next clock enters state B.
// R6: Local bus requests are refused from leaving idle until back in idle.
// R7: A local data access after idle is stalled in a remote wait state.
// R8: Half a T-state after entering B, address and data buses float.
// R9: State C raises bus owner, keeps acknowledge low, loads both wait counters; code loads one counter, from the count chosen by memory select.
// R10: In C, instruction target with high-byte flag set drives instruction write strobe.
// R11: Command select high enters D1 and opens the path into the config register.
// R12: A mode change written to config takes effect one T-state after the write.
// R13: Memory select 10 or 11 writes program counter low or high byte.
// R14: Memory select 00 asserts data write strobe, floats buses, loops through waits.
// R15: Memory select 01 with flag clear captures the byte into the low holding register.
// R16: Flag set puts byte on bits 15-8, held byte on 7-0, strobes write.
// R17: Reset clears the high-byte flag; writing select 01 also clears it.
// R18: Wait input low near end of waits adds wait states while it stays low.
// R19: Waits done and wait high enters E, raises acknowledge, holds there while requested.
// R20: Remote processor ends its write only after acknowledge returns high.
// R21: After request drops, enter F, then A3, toggling flag and bumping the counter; code toggles only for select 01 and bumps only after the high byte.
// R22: A3 drops bus owner, floats buses half a T-state, then returns to idle.
// R23: Transitions on clock edges, strobes synchronised, half-state actions on opposite phase.
`default_nettype none

package sbrw_pkg;

    // =========================================================================
    // Memory select encodings.
    localparam logic [1:0] SBRW_MS_DATA_MEMORY = 2'h0;
    localparam logic [1:0] SBRW_MS_INSTRUCTION_MEMORY = 2'h1;
    localparam logic [1:0] SBRW_MS_PCLO = 2'h2;
    localparam logic [1:0] SBRW_MS_PCHI = 2'h3;

    // =========================================================================
    // Field layout of the configuration byte written by the remote processor.
    localparam int SBRW_CFG_MS_LSB = 0;
    localparam int SBRW_CFG_MODE_LSB = 2;
    localparam logic [7:0] SBRW_CFG_RESET = 8'h00;
    localparam logic [15:0] SBRW_PC_RESET = 16'h0000;

    // =========================================================================
    // Remote access states, gray coded in the order listed.
    typedef enum logic [3:0] {
        SBRW_A1 = 4'h0,
        SBRW_A2 = 4'h1,
        SBRW_B = 4'h3,
        SBRW_C = 4'h2,
        SBRW_D1 = 4'h6,
        SBRW_D2 = 4'h7,
        SBRW_D3 = 4'h5,
        SBRW_D4 = 4'h4,
        SBRW_D5 = 4'hc,
        SBRW_D6 = 4'hd,
        SBRW_E = 4'hf,
        SBRW_F = 4'he,
        SBRW_A3 = 4'ha
    } sbrw_state_e;

endpackage

`default_nettype wire

//--- sbrw_sync.sv
`default_nettype none

module sbrw_sync (
    input wire logic core_clk_i, // Core clock.
    input wire logic rst_i,      // Asynchronous reset.
    input wire logic async_i,    // Level from outside the domain.
    output logic sync_o          // Synchronised level.
);

    logic stage1;

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            stage1 <= 1'b0;
            sync_o <= 1'b0;
        end else begin
            stage1 <= async_i;
            sync_o <= stage1;
        end
    end

endmodule

`default_nettype wire

//--- sbrw_remote_write.sv
`default_nettype none

module sbrw_remote_write
    import sbrw_pkg::*;
(
    input wire logic core_clk_i,                // CPU clock, one T-state per period.
    input wire logic rst_i,                     // Asynchronous reset, active high.
    input wire logic remote_access_enable_i,    // Remote access enable pin, active high.
    input wire logic remote_write_strobe_n_i,   // Remote write strobe pin, active low.
    input wire logic cmd_select_i,              // Command select pin: config register target.
    input wire logic wait_n_i,                  // External wait pin, active low.
    input wire logic [7:0] remote_data_i,       // Byte on the multiplexed bus from remote.
    input wire logic lock_out_remote_i,         // Lock-out-remote control bit.
    input wire logic bus_hold_i,                // Bus hold input; high allows local grants.
    input wire logic local_bus_request_i,       // Local bus request from CPU timing unit.
    input wire logic local_data_memory_access_i,       // CPU wants a data memory access.
    input wire logic [1:0] instr_wait_count_i,  // Programmed instruction wait states.
    input wire logic [2:0] data_wait_count_i,   // Programmed data wait states.
    output logic transfer_acknowledge_o,        // Acknowledge to remote, low stalls it.
    output logic local_bus_owner_n_o,           // Bus owner, high while remote owns buses.
    output logic local_bus_grant_o,             // Grant to the CPU timing unit.
    output logic remote_wait_tstate_o,          // Stalls CPU in a remote wait state.
    output logic bus_oe_n_o,                    // Address and data bus enable, low drives.
    output logic data_mem_write_strobe_n_o,     // Data memory write strobe, active low.
    output logic instr_mem_write_strobe_n_o,    // Instruction memory write strobe, low.
    output logic [15:0] instr_word_o,           // Instruction word to instruction memory.
    output logic [15:0] program_counter_o,      // Program counter.
    output logic [7:0] remote_interface_config_o, // Active config register.
    output logic high_instr_byte_flag_o         // Next instruction byte is the high one.
);

    // =========================================================================
    // Pin synchronisers.
    logic wr_strobe_n_s;
    logic wait_n_s;
    logic rae_s;
    logic cmd_s;

    // R23: synchronised strobe inputs
    sbrw_sync u_sync_wr (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .async_i(remote_write_strobe_n_i),
        .sync_o(wr_strobe_n_s)
    );

    sbrw_sync u_sync_wait (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .async_i(wait_n_i),
        .sync_o(wait_n_s)
    );

    sbrw_sync u_sync_rae (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .async_i(remote_access_enable_i),
        .sync_o(rae_s)
    );

    sbrw_sync u_sync_cmd (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .async_i(cmd_select_i),
        .sync_o(cmd_s)
    );

    logic req;
    assign req = rae_s & ~wr_strobe_n_s;

    // =========================================================================
    // State and datapath registers.
    sbrw_state_e state, next_state;
    logic [2:0] wait_cnt, next_wait_cnt;
    logic high_instr_byte_flag, next_hib;
    logic [7:0] instr_low_holding, next_instr_low_holding;
    logic [15:0] instr_word, next_instr_word;
    logic [15:0] pc, next_pc;
    logic [7:0] cfg_pending, next_cfg_pending;
    logic [7:0] cfg_active, next_cfg_active;
    logic cfg_dirty, next_cfg_dirty;
    logic grant, next_grant;
    logic ack, next_ack;
    logic owner_n, next_owner_n;
    logic remote_wait_tstate, next_twr;
    logic dwr_n, next_dwr_n;
    logic iwr_n, next_iwr_n;
    logic float_req, next_float_req;
    logic bus_oe_n;
    logic [1:0] ms;

    assign ms = cfg_active[SBRW_CFG_MS_LSB +: 2];

    function automatic logic idle_state(input sbrw_state_e s);
        idle_state = (s == SBRW_A1) || (s == SBRW_A2) || (s == SBRW_A3);
    endfunction

    // =========================================================================
    // Next-state logic.
    always_comb begin
        next_state = state;
        next_wait_cnt = wait_cnt;
        next_hib = high_instr_byte_flag;
        next_instr_low_holding = instr_low_holding;
        next_instr_word = instr_word;
        next_pc = pc;
        next_cfg_pending = cfg_pending;
        next_cfg_active = cfg_active;
        next_cfg_dirty = cfg_dirty;
        next_iwr_n = 1'b1;
        next_dwr_n = 1'b1;
        case (state)
            SBRW_A1, SBRW_A2, SBRW_A3: begin
                // R12: mode change applied one T-state after completion
                if (cfg_dirty) begin
                    next_cfg_active = cfg_pending;
                    next_cfg_dirty = 1'b0;
                    // R17: selecting instruction memory realigns the word
                    if (cfg_pending[SBRW_CFG_MS_LSB +: 2] == SBRW_MS_INSTRUCTION_MEMORY) begin
                        next_hib = 1'b0;
                    end
                end
                // R1: idle without a request
                if (!req) begin
                    next_state = SBRW_A1;
                // R2: held off by lock-out or local grant
                end else if (lock_out_remote_i || grant) begin
                    next_state = SBRW_A2;
                // R5: arbitration won
                end else if (!local_bus_request_i) begin
                    next_state = SBRW_B;
                end else begin
                    next_state = SBRW_A2;
                end
            end
            SBRW_B: begin
                // R9: load the wait counter on the way into C
                next_state = SBRW_C;
                if (ms == SBRW_MS_INSTRUCTION_MEMORY) begin
                    next_wait_cnt = {1'b0, instr_wait_count_i};
                end else begin
                    next_wait_cnt = data_wait_count_i;
                end
                // R10: early instruction strobe for the high byte
                if (!cmd_s && ms == SBRW_MS_INSTRUCTION_MEMORY && high_instr_byte_flag) begin
                    next_iwr_n = 1'b0;
                end
            end
            SBRW_C: begin
                // R11: configuration register target
                if (cmd_s) begin
                    next_state = SBRW_D1;
                    next_cfg_pending = remote_data_i;
                    next_cfg_dirty = 1'b1;
                end else begin
                    case (ms)
                        // R13: program counter bytes
                        SBRW_MS_PCLO: begin
                            next_state = SBRW_D2;
                            next_pc = {pc[15:8], remote_data_i};
                        end
                        SBRW_MS_PCHI: begin
                            next_state = SBRW_D3;
                            next_pc = {remote_data_i, pc[7:0]};
                        end
                        // R14: data memory write, remote drives buses
                        SBRW_MS_DATA_MEMORY: begin
                            next_state = SBRW_D4;
                            next_dwr_n = 1'b0;
                        end
                        default: begin
                            if (!high_instr_byte_flag) begin
                                // R15: capture low byte
                                next_state = SBRW_D5;
                                next_instr_low_holding = remote_data_i;
                            end else begin
                                // R16: assemble and write the word
                                next_state = SBRW_D6;
                                next_instr_word = {remote_data_i, instr_low_holding};
                                next_iwr_n = 1'b0;
                            end
                        end
                    endcase
                end
            end
            SBRW_D1, SBRW_D2, SBRW_D3, SBRW_D4, SBRW_D5, SBRW_D6: begin
                next_dwr_n = dwr_n;
                next_iwr_n = iwr_n;
                // R14: loop while programmed waits remain
                if (wait_cnt != 3'h0) begin
                    next_wait_cnt = wait_cnt - 3'h1;
                // R18: external wait extends the access
                end else if (wait_n_s) begin
                    // R19: waits done, enter E
                    next_state = SBRW_E;
                end
            end
            SBRW_E: begin
                next_dwr_n = ~req | dwr_n;
                next_iwr_n = ~req | iwr_n;
                // R19: hold while request stands
                if (!req) begin
                    next_state = SBRW_F;
                end
            end
            SBRW_F: begin
                // R21: flag toggle and counter increment on exit
                next_state = SBRW_A3;
                if (!cfg_dirty && ms == SBRW_MS_INSTRUCTION_MEMORY) begin
                    next_hib = ~high_instr_byte_flag;
                    if (high_instr_byte_flag) begin
                        next_pc = pc + 16'h0001;
                    end
                end
            end
            default: begin
                next_state = SBRW_A1;
            end
        endcase
        // R8: float request follows the state being entered
        next_float_req = !idle_state(next_state);
    end

    // =========================================================================
    // Handshake and arbitration outputs.
    always_comb begin
        // R4: acknowledge drops as soon as a request is seen
        next_ack = 1'b1;
        if (idle_state(next_state) == 1'b0 && next_state != SBRW_E
                && next_state != SBRW_F) begin
            next_ack = 1'b0;
        end
        if (idle_state(next_state) && req) begin
            next_ack = 1'b0;
        end
        // R9: owner high from C through F
        next_owner_n = !(next_state == SBRW_C || next_state == SBRW_D1
            || next_state == SBRW_D2 || next_state == SBRW_D3
            || next_state == SBRW_D4 || next_state == SBRW_D5
            || next_state == SBRW_D6 || next_state == SBRW_E
            || next_state == SBRW_F);
        next_owner_n = ~next_owner_n;
        // R3: grant in idle with bus hold high
        // R6: no grant outside idle
        next_grant = idle_state(next_state) && bus_hold_i && local_bus_request_i
            && !(next_state == SBRW_B);
        if (next_state == SBRW_B) begin
            next_grant = 1'b0;
        end
        // R7: stall a local data access while remote owns the buses
        next_twr = !idle_state(next_state) && local_data_memory_access_i;
    end

    // =========================================================================
    // Registers.
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state <= SBRW_A1;
            wait_cnt <= 3'h0;
            // R17: reset clears the high-byte flag
            high_instr_byte_flag <= 1'b0;
            instr_low_holding <= 8'h00;
            instr_word <= 16'h0000;
            pc <= SBRW_PC_RESET;
            cfg_pending <= SBRW_CFG_RESET;
            cfg_active <= SBRW_CFG_RESET;
            cfg_dirty <= 1'b0;
            grant <= 1'b0;
            ack <= 1'b1;
            owner_n <= 1'b0;
            remote_wait_tstate <= 1'b0;
            dwr_n <= 1'b1;
            iwr_n <= 1'b1;
            float_req <= 1'b0;
        end else begin
            state <= next_state;
            wait_cnt <= next_wait_cnt;
            high_instr_byte_flag <= next_hib;
            instr_low_holding <= next_instr_low_holding;
            instr_word <= next_instr_word;
            pc <= next_pc;
            cfg_pending <= next_cfg_pending;
            cfg_active <= next_cfg_active;
            cfg_dirty <= next_cfg_dirty;
            grant <= next_grant;
            ack <= next_ack;
            owner_n <= next_owner_n;
            remote_wait_tstate <= next_twr;
            dwr_n <= next_dwr_n;
            iwr_n <= next_iwr_n;
            float_req <= next_float_req;
        end
    end

    // R8: buses float half a T-state after entering B, kept through half of A3
    // R22: buses released back on the falling edge of A3
    always_ff @(negedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            bus_oe_n <= 1'b0;
        end else begin
            bus_oe_n <= float_req;
        end
    end

    assign transfer_acknowledge_o = ack;
    assign local_bus_owner_n_o = owner_n;
    assign local_bus_grant_o = grant;
    assign remote_wait_tstate_o = remote_wait_tstate;
    assign bus_oe_n_o = bus_oe_n;
    assign data_mem_write_strobe_n_o = dwr_n;
    assign instr_mem_write_strobe_n_o = iwr_n;
    assign instr_word_o = instr_word;
    assign program_counter_o = pc;
    assign remote_interface_config_o = cfg_active;
    assign high_instr_byte_flag_o = high_instr_byte_flag;

endmodule

`default_nettype wire

//--- sbrw_remote_write_sva.sv
`default_nettype none

module sbrw_remote_write_sva (
    input wire logic core_clk_i, // Clock.
    input wire logic rst_i, // Reset.
    input wire logic remote_access_enable_i, // Enable pin.
    input wire logic remote_write_strobe_n_i, // Write strobe pin.
    input wire logic bus_hold_i, // Bus hold.
    input wire logic local_bus_request_i, // Local request.
    input wire logic local_data_memory_access_i, // Local access.
    input wire logic transfer_acknowledge_o, // Acknowledge.
    input wire logic local_bus_owner_n_o, // Bus owner.
    input wire logic local_bus_grant_o, // Local grant.
    input wire logic remote_wait_tstate_o, // CPU stall.
    input wire logic bus_oe_n_o, // Bus enable.
    input wire logic data_mem_write_strobe_n_o, // Data strobe.
    input wire logic instr_mem_write_strobe_n_o, // Instruction strobe.
    input wire logic [15:0] program_counter_o, // Program counter.
    input wire logic high_instr_byte_flag_o // High byte flag.
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (rst_i);

    // ==========================================================
    // Handshake, bus ownership and write strobes.
    ack_on_req_a: assert property ($fell(remote_write_strobe_n_i) && remote_access_enable_i
        |-> ##[1:4] !transfer_acknowledge_o) else $error("acknowledge did not drop");
    owner_rise_a: assert property ($rose(local_bus_owner_n_o)
        |-> !transfer_acknowledge_o && bus_oe_n_o) else $error("owner rose with bad ack");
    busy_no_grant_a: assert property (local_bus_owner_n_o |-> !local_bus_grant_o)
        else $error("local grant during remote access");
    buses_float_a: assert property (local_bus_owner_n_o |-> bus_oe_n_o)
        else $error("buses driven during remote access");
    dwrite_float_a: assert property (!data_mem_write_strobe_n_o
        |-> local_bus_owner_n_o && bus_oe_n_o) else $error("data strobe outside access");
    iwrite_owner_a: assert property (!instr_mem_write_strobe_n_o |-> local_bus_owner_n_o)
        else $error("instruction strobe outside access");
    pc_moves_a: assert property (!$stable(program_counter_o)
        |-> local_bus_owner_n_o || $past(local_bus_owner_n_o)) else $error("counter moved idle");
    flag_idle_a: assert property ($changed(high_instr_byte_flag_o) |-> !local_bus_owner_n_o)
        else $error("byte flag changed mid access");
    idle_quiet_a: assert property ((!remote_access_enable_i || remote_write_strobe_n_i) [*6]
        |-> !local_bus_owner_n_o && transfer_acknowledge_o) else $error("not idle");
    grant_idle_a: assert property ((bus_hold_i && local_bus_request_i
        && !remote_access_enable_i && !local_bus_owner_n_o) [*4] |-> local_bus_grant_o)
        else $error("idle local request not granted");
    stall_cpu_a: assert property (local_data_memory_access_i && $past(local_data_memory_access_i)
        && local_bus_owner_n_o && $past(local_bus_owner_n_o) |-> remote_wait_tstate_o)
        else $error("local access not stalled");
endmodule

bind sbrw_remote_write sbrw_remote_write_sva chk (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .remote_access_enable_i(remote_access_enable_i),
    .remote_write_strobe_n_i(remote_write_strobe_n_i), .bus_hold_i(bus_hold_i),
    .local_bus_request_i(local_bus_request_i), .local_data_memory_access_i(local_data_memory_access_i),
    .transfer_acknowledge_o(transfer_acknowledge_o), .local_bus_owner_n_o(local_bus_owner_n_o),
    .local_bus_grant_o(local_bus_grant_o), .remote_wait_tstate_o(remote_wait_tstate_o),
    .bus_oe_n_o(bus_oe_n_o), .data_mem_write_strobe_n_o(data_mem_write_strobe_n_o),
    .instr_mem_write_strobe_n_o(instr_mem_write_strobe_n_o),
    .program_counter_o(program_counter_o), .high_instr_byte_flag_o(high_instr_byte_flag_o)
);

`default_nettype wire

//--- sbrw_remote_host.sv
`default_nettype none

module sbrw_remote_host (
    input wire logic clk_i, // Clock.
    input wire logic go_i, // Start one write.
    input wire logic cmd_i, // Target the config register.
    input wire logic [7:0] byte_i, // Byte to write.
    input wire logic ack_i, // Acknowledge from the device.
    output logic enable_o, // Access enable pin.
    output logic strobe_n_o, // Write strobe pin.
    output logic cmd_o, // Command select pin.
    output logic [7:0] data_o, // Bus byte.
    output logic done_o // Write finished.
);
    timeunit 1ns;
    timeprecision 100ps;

    // ==========================================================
    // Remote processor write cycle.
    initial begin
        enable_o = 1'b0;
        strobe_n_o = 1'b1;
        cmd_o = 1'b0;
        data_o = 8'h00;
        done_o = 1'b0;
        forever begin
            @(posedge clk_i iff go_i);
            #2;
            enable_o = 1'b1;
            strobe_n_o = 1'b0;
            cmd_o = cmd_i;
            data_o = byte_i;
            @(posedge clk_i iff !ack_i);
            @(posedge clk_i iff ack_i);
            #2;
            enable_o = 1'b0;
            strobe_n_o = 1'b1;
            cmd_o = ~cmd_o;
            data_o = ~data_o;
            done_o = 1'b1;
            @(posedge clk_i);
            #2;
            done_o = 1'b0;
        end
    end
endmodule

`default_nettype wire

//--- sbrw_remote_write_bench.sv
`default_nettype none

module sbrw_remote_write_bench import sbrw_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct packed {
        logic [7:0] cfg;
        logic [15:0] pc;
        logic flag;
        logic wv;
        logic [15:0] word;
    } sbrw_note_s;
    logic clk = 1'b0, rst = 1'b1, lock = 1'b0, hold = 1'b0, lreq = 1'b0, dacc = 1'b0;
    logic wait_n = 1'b1, go = 1'b0, cmd = 1'b0, e_flag = 1'b0, e_wv = 1'b0;
    logic seen_iwr = 1'b0, seen_stall = 1'b0;
    logic en, stb_n, cmd_p, done, ack, owner_n, grant, stall, oe_n, dwr_n, iwr_n, flag;
    logic [7:0] byte_v = 8'h00, e_cfg = 8'h00, e_held = 8'h00, dwr_cnt = 8'h00;
    logic [7:0] data_p, cfg;
    logic [1:0] iw = 2'h0;
    logic [2:0] dw = 3'h0;
    logic [15:0] word, pc, e_pc = 16'h0000, e_word = 16'h0000;
    logic [31:0] seed = 32'h0001221f;
    int failures = 0, checks_done = 0, cycles = 0;
    sbrw_note_s notes[$];
    sbrw_note_s nt;

    always #12.5 clk = ~clk;

    sbrw_remote_write uut (
        .core_clk_i(clk), .rst_i(rst), .remote_access_enable_i(en),
        .remote_write_strobe_n_i(stb_n), .cmd_select_i(cmd_p), .wait_n_i(wait_n),
        .remote_data_i(data_p), .lock_out_remote_i(lock), .bus_hold_i(hold),
        .local_bus_request_i(lreq), .local_data_memory_access_i(dacc), .instr_wait_count_i(iw),
        .data_wait_count_i(dw), .transfer_acknowledge_o(ack), .local_bus_owner_n_o(owner_n),
        .local_bus_grant_o(grant), .remote_wait_tstate_o(stall), .bus_oe_n_o(oe_n),
        .data_mem_write_strobe_n_o(dwr_n), .instr_mem_write_strobe_n_o(iwr_n),
        .instr_word_o(word), .program_counter_o(pc), .remote_interface_config_o(cfg),
        .high_instr_byte_flag_o(flag)
    );
    sbrw_remote_host host (
        .clk_i(clk), .go_i(go), .cmd_i(cmd), .byte_i(byte_v), .ack_i(ack), .enable_o(en),
        .strobe_n_o(stb_n), .cmd_o(cmd_p), .data_o(data_p), .done_o(done)
    );

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // ==========================================================
    // One remote write: note the expected state, then run the host.
    task automatic wr(input logic c, input logic [7:0] b);
        if (c) begin
            e_cfg = b;
            if (b[1:0] == SBRW_MS_INSTRUCTION_MEMORY) e_flag = 1'b0;
        end else if (e_cfg[1:0] == SBRW_MS_PCLO) begin
            e_pc[7:0] = b;
        end else if (e_cfg[1:0] == SBRW_MS_PCHI) begin
            e_pc[15:8] = b;
        end else if (e_cfg[1:0] == SBRW_MS_INSTRUCTION_MEMORY) begin
            if (e_flag) begin
                e_word = {b, e_held};
                e_wv = 1'b1;
                e_pc = e_pc + 16'h0001;
            end else begin
                e_held = b;
            end
            e_flag = ~e_flag;
        end
        notes.push_back('{e_cfg, e_pc, e_flag, e_wv, e_word});
        @(posedge clk);
        #2;
        cmd = c;
        byte_v = b;
        go = 1'b1;
        @(posedge clk);
        #2;
        go = 1'b0;
        @(posedge clk iff done);
        wait (notes.size() == 0);
    endtask

    always @(posedge clk) begin
        if (iwr_n === 1'b0) seen_iwr <= 1'b1;
        if (stall === 1'b1) seen_stall <= 1'b1;
        if (dwr_n === 1'b0) dwr_cnt <= dwr_cnt + 8'h01;
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles > 20000) begin
            failures++;
            stop_test();
        end
    end

    initial begin
        forever begin
            @(posedge clk iff done);
            while (owner_n !== 1'b0) @(posedge clk);
            repeat (3) @(posedge clk);
            #2;
            nt = notes.pop_front();
            chk("config", {8'h00, nt.cfg}, {8'h00, cfg});
            chk("program counter", nt.pc, pc);
            chk("high byte flag", {15'h0000, nt.flag}, {15'h0000, flag});
            if (nt.wv) chk("instr word", nt.word, word);
        end
    end

    initial begin
        repeat (10) @(posedge clk);
        #2;
        rst = 1'b0;
        @(posedge clk);
        #2;
        chk("ack idle", {15'h0000, ack}, 16'h0001);
        chk("reset flag", {15'h0000, flag}, 16'h0000);
        hold = 1'b1;
        lreq = 1'b1;
        repeat (4) @(posedge clk);
        #2;
        chk("idle grant", {15'h0000, grant}, 16'h0001);
        lock = 1'b1;
        fork
            begin
                repeat (14) @(posedge clk);
                #2;
                chk("held off", {15'h0000, owner_n}, 16'h0000);
                chk("early ack", {15'h0000, ack}, 16'h0000);
                lock = 1'b0;
                lreq = 1'b0;
            end
        join_none
        seed = xs(seed);
        wr(1'b1, {seed[7:2], SBRW_MS_PCLO});
        wr(1'b0, seed[15:8]);
        wr(1'b1, {seed[15:10], SBRW_MS_PCHI});
        wr(1'b0, seed[23:16]);
        wr(1'b1, {seed[7:2], SBRW_MS_INSTRUCTION_MEMORY});
        for (int i = 0; i < 3; i++) begin
            seed = xs(seed);
            iw = seed[9:8];
            wr(1'b0, seed[7:0]);
        end
        chk("instr strobe", {15'h0000, seen_iwr}, 16'h0001);
        wr(1'b1, {seed[15:10], SBRW_MS_INSTRUCTION_MEMORY});
        wr(1'b1, {seed[23:18], SBRW_MS_DATA_MEMORY});
        dw = 3'h3;
        wait_n = 1'b0;
        dwr_cnt = 8'h00;
        fork
            begin
                @(posedge clk iff owner_n);
                #2;
                dacc = 1'b1;
                lreq = 1'b1;
                repeat (20) @(posedge clk);
                #2;
                wait_n = 1'b1;
            end
        join_none
        wr(1'b0, seed[31:24]);
        dacc = 1'b0;
        lreq = 1'b0;
        chk("remote stall", {15'h0000, seen_stall}, 16'h0001);
        chk("data strobe held", {15'h0000, dwr_cnt >= 8'h12}, 16'h0001);
        for (int i = 0; i < 4; i++) begin
            seed = xs(seed);
            dw = seed[10:8];
            iw = seed[12:11];
            wr(1'b1, {seed[7:2], 1'b1, seed[13]});
            wr(1'b0, seed[23:16]);
        end
        stop_test();
    end
endmodule

`default_nettype wire
